// ---- logic/crypto_link_command_handler.sv ----
// Byte command interpreter between the radio byte link and the cipher core.
// Assumes the core acknowledges each start with a done pulse; tx is taken when tx_ready.
module crypto_link_command_handler
  import link_cmd_pkg::*;
#(
  parameter int PKT_LEN = PACKET_BYTES, // Bytes per packet
  parameter int USERS   = USER_COUNT    // Selectable user identities
) (
  input  wire logic       clock,         // 20 MHz clock
  input  wire logic       sys_rst,       // Async reset, active high
  input  wire logic       clk_en,        // Freezes all state when low
  input  wire logic       rx_valid,      // Received byte strobe
  input  wire logic [7:0] rx_data,       // Received byte
  input  wire logic       tx_ready,      // Radio accepts tx byte
  input  wire logic       link_ok,       // Link healthy level
  input  wire logic       enc_req,       // Next transfer is encryption
  input  wire logic       dec_req,       // Next transfer is decryption
  input  wire logic       core_done,     // Cipher core finished
  input  wire logic [7:0] core_data,     // Processed byte from core
  output logic            tx_valid,      // Tx byte valid
  output logic      [7:0] tx_data,       // Tx byte
  output logic            keygen_start,  // Start key generation pulse
  output logic            cipher_start,  // Start packet processing pulse
  output logic            cipher_encrypt,// 1 encrypt, 0 decrypt
  output logic      [3:0] user_sel,      // Selected user identity
  output logic      [3:0] byte_idx,      // Byte index to/from core
  output logic      [7:0] core_wdata,    // Byte written to core
  output logic            core_we,       // Core write strobe
  output logic            abort          // Operation abandoned pulse
);
  // Index and user fields are four bits wide
  if (PKT_LEN < 1 || PKT_LEN > 15 || USERS < 1 || USERS > 15) begin : g_bad_param
    $error("crypto_link_command_handler: bad parameter");
  end

  localparam logic [3:0] LAST_IDX = 4'(PKT_LEN - 1);
  localparam logic [3:0] MAX_USER = 4'(USERS);

  // ==========================================================
  // Command state
  state_t     state_reg, state_next;
  logic       tx_valid_reg, tx_valid_next;
  logic [7:0] tx_data_reg, tx_data_next;
  logic       kg_reg, kg_next, cs_reg, cs_next, enc_reg, enc_next;
  logic [3:0] user_reg, user_next, idx_reg, idx_next;
  logic [7:0] wdata_reg, wdata_next;
  logic       we_reg, we_next, abort_reg, abort_next;
  logic       rx_take, tx_busy, cancel_hit;

  assign tx_busy = tx_valid_reg && !tx_ready;
  // Bytes are not taken while a reply is pending
  assign rx_take = rx_valid && !tx_busy;
  // Mid-packet a cancel code is payload; every other state, and ST_COLLECT before its first byte, honours it
  assign cancel_hit = rx_take && rx_data == CODE_CANCEL
                      && !(state_reg == ST_COLLECT && (idx_reg != 4'h0 || we_reg));

  always_comb begin
    state_next    = state_reg;
    tx_valid_next = tx_valid_reg && !tx_ready;
    tx_data_next  = tx_data_reg;
    kg_next       = 1'b0;
    cs_next       = 1'b0;
    we_next       = 1'b0;
    abort_next    = 1'b0;
    enc_next      = enc_reg;
    user_next     = user_reg;
    idx_next      = idx_reg;
    wdata_next    = wdata_reg;
    if (cancel_hit) begin
      state_next    = ST_IDLE;
      abort_next    = 1'b1;
      tx_valid_next = 1'b1;
      tx_data_next  = CODE_ACK;
    end else begin
      unique case (state_reg)
        ST_IDLE: begin
          if (rx_take && rx_data == CODE_BELL && link_ok) begin
            tx_valid_next = 1'b1;
            tx_data_next  = CODE_ACK;
          end else if (rx_take && rx_data == CODE_DC1) begin
            tx_valid_next = 1'b1;
            tx_data_next  = CODE_DC1;
            state_next    = ST_CONFIRM;
          end else if (enc_req || dec_req) begin
            enc_next   = enc_req;
            state_next = enc_req ? ST_USER : ST_COLLECT;
            idx_next   = '0;
          end
        end
        ST_CONFIRM: begin
          if (rx_take && rx_data == CODE_DC2) begin
            kg_next    = 1'b1;
            state_next = ST_KEYGEN;
          end
        end
        ST_KEYGEN: begin
          if (core_done) begin
            tx_valid_next = 1'b1;
            tx_data_next  = CODE_DC2;
            state_next    = ST_DONE_WAIT;
          end
        end
        ST_DONE_WAIT: begin
          if (rx_take && rx_data == CODE_ACK) begin
            state_next = ST_IDLE;
          end
        end
        ST_USER: begin
          if (rx_take && rx_data[3:0] >= USER_MIN && rx_data[3:0] <= MAX_USER
              && rx_data[7:4] == 4'h0) begin
            user_next  = rx_data[3:0];
            state_next = ST_COLLECT;
          end
        end
        ST_COLLECT: begin
          // Index steps after each write, so back-to-back bytes still count right
          if (we_reg) begin
            idx_next = idx_reg + 4'h1;
          end
          if (rx_take) begin
            we_next    = 1'b1;
            wdata_next = rx_data;
            if (idx_next == LAST_IDX) begin
              state_next = ST_PROCESS;
            end
          end
        end
        ST_PROCESS: begin
          if (we_reg) begin
            idx_next = '0;
            cs_next  = 1'b1;
          end else if (core_done) begin
            state_next = ST_SEND;
          end
        end
        ST_SEND: begin
          if (!tx_busy) begin
            tx_valid_next = 1'b1;
            tx_data_next  = core_data;
            idx_next      = idx_reg + 4'h1;
            if (idx_reg == LAST_IDX) begin
              idx_next   = '0;
              state_next = ST_COLLECT;
            end
          end
        end
        default: state_next = ST_IDLE;
      endcase
    end
  end

  always_ff @(posedge clock or posedge sys_rst) begin
    if (sys_rst) begin
      state_reg    <= ST_IDLE;
      tx_valid_reg <= 1'b0;
      tx_data_reg  <= 8'h00;
      kg_reg       <= 1'b0;
      cs_reg       <= 1'b0;
      enc_reg      <= 1'b0;
      user_reg     <= USER_MIN;
      idx_reg      <= 4'h0;
      wdata_reg    <= 8'h00;
      we_reg       <= 1'b0;
      abort_reg    <= 1'b0;
    end else if (clk_en) begin
      state_reg    <= state_next;
      tx_valid_reg <= tx_valid_next;
      tx_data_reg  <= tx_data_next;
      kg_reg       <= kg_next;
      cs_reg       <= cs_next;
      enc_reg      <= enc_next;
      user_reg     <= user_next;
      idx_reg      <= idx_next;
      wdata_reg    <= wdata_next;
      we_reg       <= we_next;
      abort_reg    <= abort_next;
    end
  end

  assign tx_valid       = tx_valid_reg;
  assign tx_data        = tx_data_reg;
  assign keygen_start   = kg_reg;
  assign cipher_start   = cs_reg;
  assign cipher_encrypt = enc_reg;
  assign user_sel       = user_reg;
  assign byte_idx       = idx_reg;
  assign core_wdata     = wdata_reg;
  assign core_we        = we_reg;
  assign abort          = abort_reg;

  // ==========================================================
  // Checks
  a_bell_ack: assert property (@(posedge clock) disable iff (sys_rst)
    clk_en && rx_take && state_reg == ST_IDLE && rx_data == CODE_BELL && link_ok
    |=> tx_valid && tx_data == CODE_ACK)
    else $error("bell not acknowledged");
  a_cancel_ack: assert property (@(posedge clock) disable iff (sys_rst)
    clk_en && cancel_hit
    |=> abort && tx_data == CODE_ACK && state_reg == ST_IDLE)
    else $error("cancel not handled");
  a_dc1_echo: assert property (@(posedge clock) disable iff (sys_rst)
    clk_en && rx_take && state_reg == ST_IDLE && rx_data == CODE_DC1
    |=> tx_data == CODE_DC1 && !keygen_start && state_reg == ST_CONFIRM)
    else $error("request not echoed");
  a_keygen_gate: assert property (@(posedge clock) disable iff (sys_rst)
    keygen_start |-> $past(state_reg) == ST_CONFIRM)
    else $error("key generation without confirm");
  a_done_dc2: assert property (@(posedge clock) disable iff (sys_rst)
    clk_en && state_reg == ST_KEYGEN && core_done && !cancel_hit
    |=> tx_data == CODE_DC2)
    else $error("completion not reported");
  a_user_range: assert property (@(posedge clock) disable iff (sys_rst)
    user_sel >= USER_MIN && user_sel <= MAX_USER)
    else $error("user out of range");
  a_idx_range: assert property (@(posedge clock) disable iff (sys_rst)
    byte_idx <= LAST_IDX)
    else $error("byte index past packet");
  a_one_packet: assert property (@(posedge clock) disable iff (sys_rst)
    cipher_start |-> !core_we && $past(core_we) && $past(byte_idx) == LAST_IDX)
    else $error("write during processing");
  a_reset_idle: assert property (@(posedge clock) disable iff (sys_rst)
    $rose(abort) |-> state_reg == ST_IDLE)
    else $error("abort not idle");
  c_keygen: cover property (@(posedge clock) disable iff (sys_rst) keygen_start);
  c_cipher: cover property (@(posedge clock) disable iff (sys_rst) cipher_start);
  c_cancel: cover property (@(posedge clock) disable iff (sys_rst) abort);
endmodule // crypto_link_command_handler

// ---- logic/link_cmd_pkg.sv ----
// Package: control byte codes, packet size and widths for the phone command handler.
// Assumes a byte-wide receive/transmit port toward the radio module.
package link_cmd_pkg;
  localparam logic [7:0] CODE_ACK     = 8'h06;
  localparam logic [7:0] CODE_BELL    = 8'h07;
  localparam logic [7:0] CODE_DC1     = 8'h11;
  localparam logic [7:0] CODE_DC2     = 8'h12;
  localparam logic [7:0] CODE_CANCEL  = 8'h18;
  localparam int         PACKET_BYTES = 10;
  localparam int         USER_COUNT   = 9;
  localparam int         BYTE_BITS    = 8;
  localparam logic [3:0] USER_MIN     = 4'h1;
  typedef enum logic [3:0] {
    ST_IDLE, ST_CONFIRM, ST_KEYGEN, ST_DONE_WAIT, ST_USER, ST_COLLECT, ST_PROCESS, ST_SEND
  } state_t;
endpackage : link_cmd_pkg

// ---- test/radio_link_model.sv ----
// Radio module model: accepts handler tx bytes with random stalls, logs them in order.
// Assumes tx_valid and tx_data hold until a rising edge with tx_ready high.
module radio_link_model (
  input  wire logic       clock,    // Bench clock
  input  wire logic       sys_rst,  // Reset, active high
  input  wire logic       tx_valid, // Byte offered
  input  wire logic [7:0] tx_data,  // Byte offered
  output logic            tx_ready  // Byte taken this edge
);
  timeunit 1ns;
  timeprecision 1ns;
  logic [7:0] seen_q[$];
  integer     stall_seed = 32'h1d2b;
  initial tx_ready = 1'b0;
  // Stalls about one slot in four, so held bytes are exercised
  always @(negedge clock) tx_ready <= ($random(stall_seed) & 3) != 0;
  always @(posedge clock) if (!sys_rst && tx_valid && tx_ready) seen_q.push_back(tx_data);
endmodule // radio_link_model

// ---- test/tb_crypto_link_command_handler.sv ----
// Bench: acts as phone and cipher core, checks replies, strobes and packet bytes.
// Assumes link_cmd_pkg codes and a radio model that logs every accepted tx byte.
module tb_crypto_link_command_handler;
  timeunit 1ns;
  timeprecision 1ns;
  import link_cmd_pkg::*;
  logic       clock = 0, sys_rst = 1, rx_valid = 0, link_ok = 1, enc_req = 0, dec_req = 0;
  logic       core_done = 0, tx_ready, tx_valid, keygen_start, cipher_start, cipher_encrypt;
  logic       core_we, abort;
  logic [7:0] rx_data = 8'h00, core_data, tx_data, core_wdata;
  logic [3:0] user_sel, byte_idx, user;
  integer     seed = 32'h4a73, bad_count = 0, n_compared = 0;
  integer     n_key = 0, n_ciph = 0, n_abort = 0;
  logic [7:0] pkt [PACKET_BYTES];
  logic [11:0] wr_q[$];
  always #25 clock = ~clock;
  // Core model: processed byte is a fixed map of its index
  assign core_data = byte_idx ^ 8'ha5;
  always @(posedge clock) begin
    n_key   <= n_key + keygen_start;
    n_ciph  <= n_ciph + cipher_start;
    n_abort <= n_abort + abort;
    if (core_we) wr_q.push_back({byte_idx, core_wdata});
  end
  crypto_link_command_handler u_dut (
    .clock(clock), .sys_rst(sys_rst), .clk_en(1'b1), .rx_valid(rx_valid), .rx_data(rx_data),
    .tx_ready(tx_ready), .link_ok(link_ok), .enc_req(enc_req), .dec_req(dec_req),
    .core_done(core_done), .core_data(core_data), .tx_valid(tx_valid), .tx_data(tx_data),
    .keygen_start(keygen_start), .cipher_start(cipher_start), .cipher_encrypt(cipher_encrypt),
    .user_sel(user_sel), .byte_idx(byte_idx), .core_wdata(core_wdata), .core_we(core_we),
    .abort(abort));
  radio_link_model u_radio (
    .clock(clock), .sys_rst(sys_rst), .tx_valid(tx_valid), .tx_data(tx_data),
    .tx_ready(tx_ready));
  function automatic logic [7:0] cipher_byte(int i);
    return i[7:0] ^ 8'ha5;
  endfunction
  task automatic check(string what, logic [31:0] seen, logic [31:0] exp);
    n_compared++;
    if (seen !== exp) begin
      bad_count++;
      $display("wrong value %s expected %0h seen %0h", what, exp, seen);
    end
  endtask
  task automatic final_report;
    $display("compared %0d mismatches %0d", n_compared, bad_count);
    if (bad_count == 0 && n_compared > 0) $display("== PASSED ==");
    else $display("== FAILED ==");
    $finish;
  endtask
  // Waits out a pending reply, since bytes are refused meanwhile
  task automatic send(logic [7:0] b);
    int i;
    i = 0;
    @(negedge clock);
    while (tx_valid === 1'b1 && i < 200) begin
      @(negedge clock);
      i++;
    end
    rx_valid = 1'b1;
    rx_data  = b;
    @(negedge clock);
    rx_valid = 1'b0;
  endtask
  task automatic expect_tx(logic [7:0] b);
    int i;
    i = 0;
    while (u_radio.seen_q.size() == 0 && i < 300) begin
      @(negedge clock);
      i++;
    end
    check("tx byte", u_radio.seen_q.size() ? u_radio.seen_q.pop_front() : 32'h100, b);
  endtask
  task automatic done_pulse;
    @(negedge clock);
    core_done = 1'b1;
    @(negedge clock);
    core_done = 1'b0;
  endtask
  initial begin
    repeat (5) @(negedge clock);
    sys_rst = 1'b0;
    send(CODE_BELL);
    expect_tx(CODE_ACK);
    link_ok = 1'b0;
    send(CODE_BELL);
    send(8'h41);
    link_ok = 1'b1;
    repeat (10) @(negedge clock);
    check("silent tx", u_radio.seen_q.size(), 0);
    send(CODE_DC1);
    expect_tx(CODE_DC1);
    check("keygen early", n_key, 0);
    send(CODE_DC2);
    repeat (3) @(negedge clock);
    check("keygen start", n_key, 1);
    done_pulse;
    expect_tx(CODE_DC2);
    send(CODE_ACK);
    send(CODE_DC1);
    expect_tx(CODE_DC1);
    send(CODE_CANCEL);
    expect_tx(CODE_ACK);
    check("keygen count", n_key, 1);
    for (int t = 0; t < 3; t++) begin
      user = (t == 0) ? USER_MIN : 4'(USER_COUNT);
      @(negedge clock);
      if (t < 2) enc_req = 1'b1;
      else dec_req = 1'b1;
      @(negedge clock);
      enc_req = 1'b0;
      dec_req = 1'b0;
      if (t < 2) send({4'h0, user});
      for (int k = 0; k < PACKET_BYTES; k++) begin
        pkt[k] = $random(seed) & 8'h7f;
        // A cancel code opening a packet ends the transfer
        if (k == 0 && pkt[k] == CODE_CANCEL) pkt[k] = 8'h00;
        if (t == 0 && k == 3) pkt[k] = CODE_CANCEL;
        send(pkt[k]);
      end
      repeat (3) @(negedge clock);
      check("start count", n_ciph, t + 1);
      check("encrypt mode", cipher_encrypt, t < 2);
      if (t < 2) check("user", user_sel, user);
      for (int k = 0; k < PACKET_BYTES; k++)
        check("core byte", wr_q.size() ? wr_q.pop_front() : 32'hffff, {4'(k), pkt[k]});
      done_pulse;
      for (int k = 0; k < PACKET_BYTES; k++) expect_tx(cipher_byte(k));
      send(CODE_CANCEL);
      expect_tx(CODE_ACK);
    end
    check("abort count", n_abort, 4);
    final_report;
  end
  initial begin
    #(50 * 6000);
    bad_count++;
    final_report;
  end
endmodule // tb_crypto_link_command_handler
